// ==== src/cia_regs.svh ====
// Purpose: Constants for the CPU interrupt acknowledge sequencer.
// Assumes: 24-bit byte addresses, 16-bit status word, 32-bit memory data.
// Notes:   The rules the sequencer keeps are listed below.
// How it works
// - Direct dispatch used whenever direct select set
// - Direct push: status, program counter; reserved word slot left unwritten
// - Fetch base plus vector times four, jump
// - Direct mode leaves module and static base
// - Trap return discards given parameter bytes
// - Irq return signals end only when vectored, discards nothing
// - Returns restore pc, status; module when indirect
// - Maskable input level sensitive, gated by enable
// - Enable cleared on service, restored on return
// - Config bit picks vectored or non-vectored mode
// - Non-vectored still acknowledges, uses vector zero
// - Vectored takes low data byte as vector
// - End cycle: bit seven clear means done
// - Cascade entry at base plus four times index
// - Negative vector reads cascade address, unsigned vector
// - Cascaded return runs cascaded end cycle, discards
// - Every nonmaskable falling edge raises an interrupt
// - Nonmaskable acknowledge at FFFF00, vector one
// - Nonmaskable return uses trap return, no cycles
// - Cascading reaches 256 levels via master only
// - Indirect: push module, load descriptor fields
// - Status 0100 master acknowledge, 0101 cascaded
`ifndef CIA_REGS_SVH
`define CIA_REGS_SVH
`define CIA_NMI_ACK_ADDR   24'hffff00
`define CIA_INT_ACK_ADDR   24'hfffe00
`define CIA_ST_ACK_MASTER  4'h4
`define CIA_ST_ACK_CASC    4'h5
`define CIA_ST_EOI_MASTER  4'h6
`define CIA_ST_EOI_CASC    4'h7
`define CIA_ST_MEM         4'ha
`define CIA_VEC_NMI        8'h01
`define CIA_VEC_NONVEC     8'h00
`define CIA_PSR_I_BIT      11
`define CIA_PSR_CLR_MASK   16'hf51f
`define CIA_PB_OFFSET      24'h000008
`define CIA_CASC_MIN       8'hf0
`endif

// ==== src/cia_pkg.sv ====
// Purpose: Types for the CPU interrupt acknowledge sequencer.
// Assumes: Used as cia_pkg::name, never imported.
// Notes:   State codes are binary and fixed.
package cia_pkg;
  typedef enum logic [4:0] {
    cia_idle      = 5'h00,
    cia_ack       = 5'h01,
    cia_casc_tbl  = 5'h02,
    cia_casc_ack  = 5'h03,
    cia_push_psr  = 5'h04,
    cia_fetch_idt = 5'h05,
    cia_push_mod  = 5'h06,
    cia_read_sb   = 5'h07,
    cia_read_pb   = 5'h08,
    cia_push_pc   = 5'h09,
    cia_done      = 5'h0a,
    cia_pop_pc    = 5'h0b,
    cia_pop_mod   = 5'h0c,
    cia_pop_psr   = 5'h0d,
    cia_eoi       = 5'h0e,
    cia_eoi_tbl   = 5'h0f,
    cia_eoi_casc  = 5'h10,
    cia_rsb       = 5'h11
  } cia_state_type;
  typedef enum logic [1:0] {
    cia_bus_none  = 2'h0,
    cia_bus_read  = 2'h1,
    cia_bus_write = 2'h2
  } cia_bus_type;
endpackage

// ==== src/cia_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Input is a free level from outside the core_clk domain.
// Notes:   Only the second stage is visible to any logic.
`timescale 1ns/1ps
module cia_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cia_sync_state_type;
  cia_sync_state_type st;
  cia_sync_state_type next_st;

  // Pins idle high, so reset to high to avoid a false edge
  always_comb begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
    if (srst) begin
      next_st = '1;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign sync_out = st.stable;
endmodule

// ==== src/cia_nmi_edge.sv ====
// Purpose: Nonmaskable falling-edge latch.
// Assumes: Input already synchronised to core_clk.
// Notes:   A new edge in the cycle of the clear is kept.
`timescale 1ns/1ps
module cia_nmi_edge (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic nmi_level_n,
  input  wire logic pend_clear,
  output logic      pend
);
  typedef struct packed {
    logic prev;
    logic pend;
  } cia_edge_state_type;
  cia_edge_state_type st;
  cia_edge_state_type next_st;
  logic fall;

  // Every falling edge latches a request; set wins over clear
  always_comb begin
    fall         = st.prev & ~nmi_level_n;
    next_st.prev = nmi_level_n;
    next_st.pend = fall | (st.pend & ~pend_clear);
    if (srst) begin
      next_st.prev = 1'b1;
      next_st.pend = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign pend = st.pend;
endmodule

// ==== src/cia_top.sv ====
// Purpose: Interrupt acknowledge, dispatch and return sequencer.
// Assumes: One bus access at a time, finished by bus_done with bus_rdata.
// Notes:   The core pulses boundary, trap_ret or irq_ret; done pulses back.
`timescale 1ns/1ps
`include "cia_regs.svh"
module cia_top (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        maskable_irq_n,
  input  wire logic        nonmaskable_irq_n,
  input  wire logic        direct_exception_select,
  input  wire logic        vector_select,
  input  wire logic [23:0] dispatch_base_pointer,
  input  wire logic [15:0] status_word,
  input  wire logic [15:0] module_in,
  input  wire logic [23:0] stack_pointer_in,
  input  wire logic [23:0] return_address,
  input  wire logic        boundary,
  input  wire logic        trap_ret,
  input  wire logic        irq_ret,
  input  wire logic [15:0] param_bytes,
  input  wire logic        bus_done,
  input  wire logic [31:0] bus_rdata,
  output logic             bus_req,
  output logic [1:0]       bus_kind,
  output logic [23:0]      bus_addr,
  output logic [3:0]       bus_status,
  output logic [31:0]      bus_wdata,
  output logic             busy,
  output logic             done,
  output logic             load_regs,
  output logic [23:0]      new_pc,
  output logic [15:0]      new_status,
  output logic [15:0]      new_module,
  output logic             load_module,
  output logic [31:0]      new_static_base,
  output logic             load_static_base,
  output logic [23:0]      new_stack_pointer
);
  typedef struct packed {
    cia_pkg::cia_state_type fsm;
    logic                   is_nmi;
    logic                   is_ret;
    logic                   is_irq_ret;
    logic                   direct;
    logic [7:0]             vector;
    logic [31:0]            entry;
    logic [15:0]            psr_copy;
    logic [23:0]            sp;
    logic                   bus_req;
    logic [1:0]             bus_kind;
    logic [23:0]            bus_addr;
    logic [3:0]             bus_status;
    logic [31:0]            bus_wdata;
    logic                   busy;
    logic                   done;
    logic                   load_regs;
    logic [23:0]            new_pc;
    logic [15:0]            new_status;
    logic [15:0]            new_module;
    logic                   load_module;
    logic [31:0]            new_static_base;
    logic                   load_static_base;
  } cia_top_state_type;
  cia_top_state_type st;
  cia_top_state_type next_st;
  logic [1:0]        pins_sync;
  logic              nmi_pend;
  logic              nmi_take;

  // Both interrupt pins are asynchronous
  cia_sync #(.WIDTH(2)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({nonmaskable_irq_n, maskable_irq_n}),
    .sync_out (pins_sync)
  );

  cia_nmi_edge u_edge (
    .core_clk    (core_clk),
    .srst        (srst),
    .nmi_level_n (pins_sync[1]),
    .pend_clear  (nmi_take),
    .pend        (nmi_pend)
  );

  // Table slot: base plus signed index times four
  function automatic logic [23:0] cia_slot(input logic [23:0] base,
                                           input logic [7:0]  idx);
    logic [23:0] off;
    off = {{14{idx[7]}}, idx, 2'b00};
    cia_slot = base + off;
  endfunction

  // Start a bus access with the given kind, address and status code
  function automatic cia_top_state_type cia_go(
      input cia_top_state_type s, input cia_pkg::cia_bus_type k,
      input logic [23:0] a, input logic [3:0] c, input logic [31:0] d);
    cia_top_state_type r;
    r            = s;
    r.bus_req    = 1'b1;
    r.bus_kind   = k;
    r.bus_addr   = a;
    r.bus_status = c;
    r.bus_wdata  = d;
    cia_go = r;
  endfunction

  assign nmi_take = (st.fsm == cia_pkg::cia_idle) & boundary & nmi_pend;

  // Sequencer: one bus access per state, advanced by bus_done
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.load_regs        = 1'b0;
    next_st.load_module      = 1'b0;
    next_st.load_static_base = 1'b0;
    if (st.bus_req & bus_done) begin
      next_st.bus_req = 1'b0;
    end
    case (st.fsm)
      cia_pkg::cia_idle: begin
        next_st.busy   = 1'b0;
        next_st.direct = direct_exception_select;
        next_st.sp     = stack_pointer_in;
        next_st.psr_copy = status_word;
        if (nmi_take) begin
          // Nonmaskable beats maskable and ignores the enable flag
          next_st.is_nmi = 1'b1;
          next_st.is_ret = 1'b0;
          next_st.busy   = 1'b1;
          next_st.fsm    = cia_pkg::cia_ack;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           `CIA_NMI_ACK_ADDR, `CIA_ST_ACK_MASTER,
                           32'h0000_0000);
        end else if (boundary & ~pins_sync[0] &
                     status_word[`CIA_PSR_I_BIT]) begin
          next_st.is_nmi = 1'b0;
          next_st.is_ret = 1'b0;
          next_st.busy   = 1'b1;
          next_st.fsm    = cia_pkg::cia_ack;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           `CIA_INT_ACK_ADDR, `CIA_ST_ACK_MASTER,
                           32'h0000_0000);
        end else if (trap_ret | irq_ret) begin
          next_st.is_ret     = 1'b1;
          next_st.is_nmi     = 1'b0;
          next_st.is_irq_ret = irq_ret & ~trap_ret;
          next_st.busy       = 1'b1;
          next_st.fsm        = cia_pkg::cia_pop_pc;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           stack_pointer_in, `CIA_ST_MEM,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_ack: begin
        if (bus_done) begin
          if (st.is_nmi) begin
            next_st.vector = `CIA_VEC_NMI;
            next_st.fsm    = cia_pkg::cia_push_psr;
          end else if (~vector_select) begin
            next_st.vector = `CIA_VEC_NONVEC;
            next_st.fsm    = cia_pkg::cia_push_psr;
          end else if (~bus_rdata[7]) begin
            next_st.vector = bus_rdata[7:0];
            next_st.fsm    = cia_pkg::cia_push_psr;
          end else begin
            // Below -16 is reserved; treat as -16..-1 anyway
            next_st.vector = bus_rdata[7:0];
            next_st.fsm    = cia_pkg::cia_casc_tbl;
            next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                             cia_slot(dispatch_base_pointer,
                                      bus_rdata[7:0]),
                             `CIA_ST_MEM, 32'h0000_0000);
          end
        end
      end
      cia_pkg::cia_casc_tbl: begin
        if (bus_done) begin
          next_st.fsm = cia_pkg::cia_casc_ack;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           bus_rdata[23:0], `CIA_ST_ACK_CASC,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_casc_ack: begin
        if (bus_done) begin
          next_st.vector = bus_rdata[7:0];
          next_st.fsm    = cia_pkg::cia_push_psr;
        end
      end
      cia_pkg::cia_push_psr: begin
        // Status copy goes first; live flag is cleared
        next_st.fsm = cia_pkg::cia_fetch_idt;
        next_st = cia_go(next_st, cia_pkg::cia_bus_write,
                         st.sp - 24'h000002, `CIA_ST_MEM,
                         {16'h0000, st.psr_copy});
        next_st.new_status = st.psr_copy & `CIA_PSR_CLR_MASK;
      end
      cia_pkg::cia_fetch_idt: begin
        if (bus_done) begin
          next_st.fsm = cia_pkg::cia_push_mod;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           dispatch_base_pointer + {14'h0000,
                           st.vector, 2'b00},
                           `CIA_ST_MEM, 32'h0000_0000);
        end
      end
      cia_pkg::cia_push_mod: begin
        if (bus_done) begin
          next_st.entry = bus_rdata;
          if (st.direct) begin
            // Reserved slot left unwritten; module untouched
            next_st.new_pc = bus_rdata[23:0];
            next_st.fsm    = cia_pkg::cia_push_pc;
          end else begin
            next_st.new_module = bus_rdata[15:0];
            next_st.fsm = cia_pkg::cia_read_sb;
            next_st = cia_go(next_st, cia_pkg::cia_bus_write,
                             st.sp - 24'h000004, `CIA_ST_MEM,
                             {16'h0000, module_in});
          end
        end
      end
      cia_pkg::cia_read_sb: begin
        if (bus_done) begin
          next_st.fsm = cia_pkg::cia_read_pb;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           {8'h00, st.new_module}, `CIA_ST_MEM,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_read_pb: begin
        if (bus_done) begin
          next_st.new_static_base = bus_rdata;
          next_st.fsm = cia_pkg::cia_push_pc;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           {8'h00, st.new_module} + `CIA_PB_OFFSET,
                           `CIA_ST_MEM, 32'h0000_0000);
        end
      end
      cia_pkg::cia_push_pc: begin
        if (~st.bus_req | bus_done) begin
          if (~st.direct) begin
            next_st.new_pc = bus_rdata[23:0] + {8'h00, st.entry[31:16]};
          end
          next_st.sp  = st.sp - 24'h000008;
          next_st.fsm = cia_pkg::cia_done;
          next_st = cia_go(next_st, cia_pkg::cia_bus_write,
                           st.sp - 24'h000008, `CIA_ST_MEM,
                           {8'h00, return_address});
        end
      end
      cia_pkg::cia_pop_pc: begin
        if (bus_done) begin
          next_st.new_pc = bus_rdata[23:0];
          next_st.fsm    = cia_pkg::cia_pop_mod;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           st.sp + 24'h000004, `CIA_ST_MEM,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_pop_mod: begin
        if (bus_done) begin
          next_st.new_module = bus_rdata[15:0];
          next_st.fsm = cia_pkg::cia_pop_psr;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           st.sp + 24'h000006, `CIA_ST_MEM,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_pop_psr: begin
        if (bus_done) begin
          next_st.new_status = bus_rdata[15:0];
          next_st.sp = st.sp + 24'h000008 +
                       (st.is_irq_ret ? 24'h000000
                                      : {8'h00, param_bytes});
          if (st.is_irq_ret & vector_select) begin
            next_st.fsm = cia_pkg::cia_eoi_tbl;
            next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                             `CIA_INT_ACK_ADDR, `CIA_ST_EOI_MASTER,
                             32'h0000_0000);
          end else begin
            next_st.fsm = cia_pkg::cia_rsb;
          end
        end
      end
      cia_pkg::cia_eoi_tbl: begin
        if (bus_done) begin
          if (~bus_rdata[7]) begin
            next_st.fsm = cia_pkg::cia_rsb;
          end else begin
            next_st.fsm = cia_pkg::cia_eoi;
            next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                             cia_slot(dispatch_base_pointer,
                                      bus_rdata[7:0]),
                             `CIA_ST_MEM, 32'h0000_0000);
          end
        end
      end
      cia_pkg::cia_eoi: begin
        if (bus_done) begin
          next_st.fsm = cia_pkg::cia_eoi_casc;
          next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                           bus_rdata[23:0], `CIA_ST_EOI_CASC,
                           32'h0000_0000);
        end
      end
      cia_pkg::cia_eoi_casc: begin
        if (bus_done) begin
          next_st.fsm = cia_pkg::cia_rsb;
        end
      end
      cia_pkg::cia_rsb: begin
        // Static base reloaded from the restored module only when indirect
        if (~st.direct) begin
          if (~st.bus_req) begin
            next_st = cia_go(next_st, cia_pkg::cia_bus_read,
                             {8'h00, st.new_module}, `CIA_ST_MEM,
                             32'h0000_0000);
          end else if (bus_done) begin
            next_st.new_static_base  = bus_rdata;
            next_st.load_module      = 1'b1;
            next_st.load_static_base = 1'b1;
            next_st.load_regs = 1'b1;
            next_st.done      = 1'b1;
            next_st.fsm       = cia_pkg::cia_idle;
          end
        end else begin
          next_st.load_regs = 1'b1;
          next_st.done      = 1'b1;
          next_st.fsm       = cia_pkg::cia_idle;
        end
      end
      cia_pkg::cia_done: begin
        if (bus_done) begin
          next_st.load_regs        = 1'b1;
          next_st.load_module      = ~st.direct;
          next_st.load_static_base = ~st.direct;
          next_st.done             = 1'b1;
          next_st.fsm              = cia_pkg::cia_idle;
        end
      end
      default: begin
        next_st.fsm = cia_pkg::cia_idle;
      end
    endcase
    if (srst) begin
      next_st = '0;
      next_st.fsm = cia_pkg::cia_idle;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  assign bus_req           = st.bus_req;
  assign bus_kind          = st.bus_kind;
  assign bus_addr          = st.bus_addr;
  assign bus_status        = st.bus_status;
  assign bus_wdata         = st.bus_wdata;
  assign busy              = st.busy;
  assign done              = st.done;
  assign load_regs         = st.load_regs;
  assign new_pc            = st.new_pc;
  assign new_status        = st.new_status;
  assign new_module        = st.new_module;
  assign load_module       = st.load_module;
  assign new_static_base   = st.new_static_base;
  assign load_static_base  = st.load_static_base;
  assign new_stack_pointer = st.sp;
endmodule

// ==== dv/cia_top_props.sv ====
// Purpose: Port-level checks for the acknowledge and return sequencer.
// Assumes: Bound to cia_top; bus access held until bus_done.
// Notes:   Only ports are visible, so vectors are caught from bus data.
`timescale 1ns/1ps
module cia_top_props (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        direct_exception_select,
  input wire logic        vector_select,
  input wire logic [23:0] dispatch_base_pointer,
  input wire logic        bus_done,
  input wire logic [31:0] bus_rdata,
  input wire logic        bus_req,
  input wire logic [1:0]  bus_kind,
  input wire logic [23:0] bus_addr,
  input wire logic [3:0]  bus_status,
  input wire logic        done,
  input wire logic        load_regs,
  input wire logic        load_module,
  input wire logic        load_static_base
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [7:0]  ack_byte;
  logic [23:0] last_mem;
  logic [23:0] casc_slot;
  // Remember the master byte and the last memory word read
  always_ff @(posedge core_clk) begin
    if (bus_req && bus_done && bus_status == 4'h4) begin
      ack_byte <= bus_rdata[7:0];
    end
    if (bus_req && bus_done && bus_status == 4'ha) begin
      last_mem <= bus_rdata[23:0];
    end
  end
  // A negative byte indexes below the base, four bytes a slot
  assign casc_slot = dispatch_base_pointer
                     + {{14{ack_byte[7]}}, ack_byte, 2'b00};
  sequence s_ack_end(logic [23:0] a);
    bus_req && bus_done && bus_status == 4'h4 && bus_addr == a;
  endsequence
  sequence s_read_at(logic [23:0] a);
    bus_req && bus_kind == 2'h1 && bus_addr == a;
  endsequence
  a_ack_status_ok: assert property (bus_req && bus_status == 4'h4 |->
    bus_kind == 2'h1 && bus_addr inside {24'hfffe00, 24'hffff00})
    else $error("acknowledge cycle with wrong address or kind");
  a_req_holds: assert property (bus_req && !bus_done |=> bus_req &&
    $stable(bus_addr) && $stable(bus_status))
    else $error("bus request changed before completion");
  a_vec_index: assert property (s_ack_end(24'hfffe00) ##0
    (vector_select && !bus_rdata[7]) |=> ##[0:12]
    s_read_at(dispatch_base_pointer + {14'h0, ack_byte, 2'b00}))
    else $error("vectored table read at wrong address");
  a_nonvec_zero: assert property (s_ack_end(24'hfffe00) ##0
    !vector_select |=> ##[0:12] s_read_at(dispatch_base_pointer))
    else $error("non-vectored entry did not use vector zero");
  a_nmi_vec_one: assert property (s_ack_end(24'hffff00) |=>
    ##[0:12] s_read_at(dispatch_base_pointer + 24'h000004))
    else $error("nonmaskable entry did not use vector one");
  a_casc_slot: assert property (s_ack_end(24'hfffe00) ##0
    (vector_select && bus_rdata[7]) |=> ##[0:4] s_read_at(casc_slot))
    else $error("cascade table slot address wrong");
  a_casc_addr: assert property (bus_req &&
    bus_status inside {4'h5, 4'h7} |-> bus_addr == last_mem)
    else $error("cascaded cycle not at cascade address");
  a_eoi_plain: assert property (bus_req && bus_done &&
    bus_status == 4'h6 && !bus_rdata[7] |=>
    !(bus_req && bus_status == 4'h7) [*6])
    else $error("cascaded end cycle after positive byte");
  a_load_with_done: assert property ((load_regs || load_module) |-> done)
    else $error("register load outside completion");
  a_direct_no_mod: assert property ((load_module ||
    load_static_base) |-> !direct_exception_select)
    else $error("module loaded in direct mode");
endmodule
bind cia_top cia_top_props u_props (.core_clk, .srst,
  .direct_exception_select, .vector_select, .dispatch_base_pointer,
  .bus_done, .bus_rdata, .bus_req, .bus_kind, .bus_addr, .bus_status,
  .done, .load_regs, .load_module, .load_static_base);

// ==== dv/cia_icu_model.sv ====
// Purpose: Behavioural master and cascaded interrupt controllers.
// Assumes: Bus request held until bus_done; one access at a time.
// Notes:   Memory reads return address plus 100 hex as a pattern.
`timescale 1ns/1ps
module cia_icu_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        bus_req,
  input  wire logic [23:0] bus_addr,
  input  wire logic [3:0]  bus_status,
  input  wire logic        int_req,
  input  wire logic [7:0]  mvec,
  input  wire logic [7:0]  cvec,
  output logic             bus_done,
  output logic [31:0]      bus_rdata,
  output logic             maskable_irq_n
);
  logic [1:0] wait_cnt;
  logic       slow;
  // Only the master drives the core request pin
  assign maskable_irq_n = !int_req;
  // Answer fast and slow in turn; idle data toggles so stale reads show
  always_ff @(posedge core_clk) begin
    bus_done <= 1'b0;
    if (srst) begin
      wait_cnt  <= 2'h0;
      slow      <= 1'b0;
      bus_rdata <= 32'h0;
    end else if (bus_req && !bus_done) begin
      if (wait_cnt == {slow, slow}) begin
        bus_done <= 1'b1;
        wait_cnt <= 2'h0;
        slow     <= !slow;
        case (bus_status)
          4'h4, 4'h6: bus_rdata <= {24'h0, mvec};
          4'h5:       bus_rdata <= {24'h0, cvec};
          4'h7:       bus_rdata <= 32'h00000033;
          default:    bus_rdata <= {8'h00, bus_addr + 24'h000100};
        endcase
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end else begin
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule

// ==== dv/tb_cpu_interrupt_acknowledge.sv ====
// Purpose: Self-checking bench for the acknowledge and return sequencer.
// Assumes: Controller model answers every bus access.
// Notes:   Expected addresses follow the model's address-plus-100 pattern.
`timescale 1ns/1ps
module tb_cpu_interrupt_acknowledge;
  logic        core_clk, srst, nmi_n, dsel, vsel, bnd, tret, iret;
  logic        int_req, irq_n, bus_req, bus_done, busy, done, load_mod;
  logic [23:0] base, sp, bus_addr, new_pc, new_sp;
  logic [15:0] psw, pbytes, new_status, new_mod;
  logic [7:0]  mvec, cvec;
  logic [3:0]  bus_status;
  logic [31:0] bus_rdata, new_sb;
  int          fails, comparisons, n_eoi, n_ceoi, n_mod, k;
  cia_top uut (.core_clk(core_clk), .srst(srst), .maskable_irq_n(irq_n),
    .nonmaskable_irq_n(nmi_n), .direct_exception_select(dsel),
    .vector_select(vsel), .dispatch_base_pointer(base),
    .status_word(psw), .module_in(16'h0040), .stack_pointer_in(sp),
    .return_address(24'h000200), .boundary(bnd), .trap_ret(tret),
    .irq_ret(iret), .param_bytes(pbytes), .bus_done(bus_done),
    .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_kind(),
    .bus_addr(bus_addr), .bus_status(bus_status), .bus_wdata(),
    .busy(busy), .done(done), .load_regs(), .new_pc(new_pc),
    .new_status(new_status), .new_module(new_mod), .load_module(load_mod),
    .new_static_base(new_sb), .load_static_base(),
    .new_stack_pointer(new_sp));
  cia_icu_model icu (.core_clk(core_clk), .srst(srst), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_status(bus_status), .int_req(int_req),
    .mvec(mvec), .cvec(cvec), .bus_done(bus_done),
    .bus_rdata(bus_rdata), .maskable_irq_n(irq_n));
  // Clock at 20 MHz
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Count end-of-service cycles and module loads seen at the ports
  always @(posedge core_clk) begin
    if (bus_req === 1'b1 && bus_done === 1'b1) begin
      if (bus_status === 4'h6) n_eoi++;
      if (bus_status === 4'h7) n_ceoi++;
    end
    if (load_mod === 1'b1) n_mod++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Pulse one start input: 0 boundary, 1 trap return, 2 irq return,
  // 3 boundary with no wait for done
  task automatic run(input int which);
    int i;
    @(posedge core_clk);
    bnd  <= (which == 0 || which == 3);
    tret <= (which == 1);
    iret <= (which == 2);
    @(posedge core_clk);
    bnd  <= 1'b0;
    tret <= 1'b0;
    iret <= 1'b0;
    for (i = 0; which < 3 && i < 300 && done !== 1'b1; i++)
      @(posedge core_clk);
    if (i == 300) begin
      fails++;
      tally_and_finish;
    end
  endtask
  // Main sequence
  initial begin
    srst = 1'b1; nmi_n = 1'b1; dsel = 1'b1; vsel = 1'b1; bnd = 1'b0;
    tret = 1'b0; iret = 1'b0; int_req = 1'b0; base = 24'h001000;
    sp = 24'h008000; psw = 16'h0800; pbytes = 16'h0010;
    mvec = 8'h05; cvec = 8'hc8; fails = 0; comparisons = 0;
    n_eoi = 0; n_ceoi = 0; n_mod = 0;
    repeat (2) @(posedge core_clk);
    srst    <= 1'b0;
    int_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    run(0);
    chk(32'(new_pc), 32'h00001114);
    chk(32'(new_status[11]), 32'h0);
    chk(32'(new_sp), 32'h00007ff8);
    mvec <= 8'hf2;
    run(0);
    chk(32'(new_pc), 32'h00001420);
    vsel <= 1'b0;
    mvec <= 8'h7f;
    run(0);
    chk(32'(new_pc), 32'h00001100);
    // Interrupts disabled: a boundary must not start a sequence
    psw <= 16'h0000;
    run(3);
    for (k = 0; k < 6; k++) begin
      @(posedge core_clk);
      chk(32'(busy), 32'h0);
    end
    for (k = 0; k < 2; k++) begin
      nmi_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      run(0);
      chk(32'(new_pc), 32'h00001104);
      nmi_n <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
    int_req <= 1'b0;
    dsel    <= 1'b0;
    vsel    <= 1'b1;
    mvec    <= 8'h05;
    run(1);
    chk(32'(new_sp), 32'h00008018);
    chk(32'(new_pc), 32'h00008100);
    chk(32'(n_eoi), 32'h0);
    chk(32'(new_mod), 32'h00008104);
    chk(new_sb, 32'h00008204);
    run(2);
    chk(32'(new_sp), 32'h00008008);
    chk(32'(n_eoi), 32'h1);
    chk(32'(n_ceoi), 32'h0);
    mvec <= 8'hf2;
    run(2);
    chk(32'(n_ceoi), 32'h1);
    @(posedge core_clk);
    chk(32'(n_mod), 32'h3);
    tally_and_finish;
  end
endmodule
